// ### core/sticky_interrupt_router.sv
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
// Functional notes
// R01: Four destinations; processor interrupts use replication indices 0 and 1.
// R02: Pin destinations use replication indices 2 and 3.
// R03: Everything inside is active high; polarity fixed at entry and exit.
// R04: Raw status shows each source's present unlatched value.
// R05: Level mode sets the flag every cycle the source is active.
// R06: Any-edge mode sets the flag on every change of the source.
// R07: Falling mode sets the flag on active to inactive only.
// R08: Rising mode sets the flag on inactive to active only.
// R09: Writing one clears a flag; a same-cycle event sets it again.
// R10: Pending bit is flag and enable; only pending sources go forward.
// R11: Skip bit uses the raw value instead of the flag.
// R12: Software skips latching only for sources already sticky at their origin.
// R13: Each destination has its own mask driving its interrupt.
// R14: Each destination shows its active, enabled, mapped sources.
// R15: Each port module input has a polarity bit applied first.
// R16: Port module bits behave exactly like the top-level source bits.
// R17: All pending port module bits are ORed into source bit 0.
// R18: Two pin inputs and two pin outputs, independent, own polarity each.
// R19: Drive mode 0 drives the output pin at both levels.
// R20: Drive mode 1 with polarity 0 emulates open collector, low when asserted.
// R21: Software sets drive and polarity before enabling the pin overlay.
// R22: Bit 0 is the port module aggregate, bits 1 and 2 the pins.
// R23: In open-collector mode the driver is off while not asserted.
module sticky_interrupt_router
  import intr_pkg::*;
(
  // Clock and reset.
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  // Register port.
  input  wire reg_req_s               bus_req,
  output logic [31:0]                 bus_rdata,
  // Interrupt sources.
  input  wire logic [SRC_N-SRC_BLK-1:0] block_irq,
  input  wire logic [PM_N-1:0]        portmod_irq,
  input  wire logic                   irq_input_a,
  input  wire logic                   irq_input_b,
  // Destinations.
  output logic                        processor_irq_a,
  output logic                        processor_irq_b,
  output logic                        irq_output_a,
  output logic                        irq_output_a_oe,
  output logic                        irq_output_b,
  output logic                        irq_output_b_oe
);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  logic [EXT_N-1:0]   pin_meta_reg;
  logic [EXT_N-1:0]   pin_sync_reg;
  logic [EXT_N-1:0]   pin_input_polarity_reg;
  logic [EXT_N-1:0]   pin_output_polarity_reg;
  logic [EXT_N-1:0]   pin_output_drive_mode_reg;
  logic [EXT_N-1:0]   pin_level;
  logic [PM_N-1:0]    portmod_polarity_reg;
  logic [PM_N-1:0]    portmod_latch_skip_reg;
  logic [PM_N-1:0]    portmod_latched_flag_reg;
  logic [PM_N-1:0]    portmod_enable_mask_reg;
  logic [PM_N-1:0]    pm_prev_reg;
  logic [2*PM_N-1:0]  portmod_detect_mode_reg;
  logic [PM_N-1:0]    portmod_raw_level;
  logic [PM_N-1:0]    pm_hit;
  logic [PM_N-1:0]    pm_clear;
  logic [PM_N-1:0]    portmod_pending_enabled;
  logic [SRC_N-1:0]   source_latch_skip_reg;
  logic [SRC_N-1:0]   source_latched_flag_reg;
  logic [SRC_N-1:0]   source_enable_mask_reg;
  logic [SRC_N-1:0]   src_prev_reg;
  logic [2*SRC_N-1:0] source_detect_mode_reg;
  logic [SRC_N-1:0]   source_raw_level;
  logic [SRC_N-1:0]   src_hit;
  logic [SRC_N-1:0]   src_clear;
  logic [SRC_N-1:0]   source_pending_enabled;
  logic [SRC_N-1:0]   target_source_mask_reg [DST_N];
  logic [SRC_N-1:0]   target_pending_view [DST_N];
  logic [DST_N-1:0]   dst_active;
  logic [DST_N-1:0]   dst_reg;
  logic [31:0]        rdata_next;

  ////////////////////////////////////////////////////////////////////////////
  // Pins pass two flops; they reset to the idle level, so no false event follows reset.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pin_meta_reg <= PIN_IDLE_RST;
      pin_sync_reg <= PIN_IDLE_RST;
    end else begin
      pin_meta_reg <= {irq_input_b, irq_input_a};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // R03: Polarity fixed at entry.
  // R18: Each pin input has its own polarity bit; 1 means active high.
  assign pin_level = ~(pin_sync_reg ^ pin_input_polarity_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers written by software.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      source_latch_skip_reg     <= SRC_RST;
      source_enable_mask_reg    <= SRC_RST;
      source_detect_mode_reg    <= SRC_MODE_RST;
      portmod_polarity_reg      <= PM_POL_RST;
      portmod_latch_skip_reg    <= PM_RST;
      portmod_enable_mask_reg   <= PM_RST;
      portmod_detect_mode_reg   <= PM_MODE_RST;
      pin_input_polarity_reg    <= PIN_RST;
      pin_output_polarity_reg   <= PIN_RST;
      pin_output_drive_mode_reg <= PIN_RST;
    end else if (bus_req.wr) begin
      case (bus_req.addr)
        OFF_SRC_SKIP:    source_latch_skip_reg <= bus_req.wdata[SRC_N-1:0];
        OFF_SRC_ENA:     source_enable_mask_reg <= bus_req.wdata[SRC_N-1:0];
        OFF_SRC_MODE_LO: source_detect_mode_reg[MODE_LO_W-1:0] <= bus_req.wdata;
        OFF_SRC_MODE_HI: source_detect_mode_reg[2*SRC_N-1:MODE_LO_W] <=
          bus_req.wdata[2*SRC_N-MODE_LO_W-1:0];
        OFF_PM_POL:      portmod_polarity_reg <= bus_req.wdata[PM_N-1:0];
        OFF_PM_SKIP:     portmod_latch_skip_reg <= bus_req.wdata[PM_N-1:0];
        OFF_PM_ENA:      portmod_enable_mask_reg <= bus_req.wdata[PM_N-1:0];
        OFF_PM_MODE:     portmod_detect_mode_reg <= bus_req.wdata[2*PM_N-1:0];
        OFF_PIN_IN_POL:  pin_input_polarity_reg <= bus_req.wdata[EXT_N-1:0];
        OFF_PIN_OUT_POL: pin_output_polarity_reg <= bus_req.wdata[EXT_N-1:0];
        OFF_PIN_DRV:     pin_output_drive_mode_reg <= bus_req.wdata[EXT_N-1:0];
        default:         ;
      endcase
    end
  end

  // One mask per destination; the stride keeps each at its replication index.
  generate
    for (genvar d = 0; d < DST_N; d++) begin : g_map
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          target_source_mask_reg[d] <= SRC_RST;
        end else if (bus_req.wr && bus_req.addr == 8'(OFF_DST_MAP + DST_STRIDE * d)) begin
          target_source_mask_reg[d] <= bus_req.wdata[SRC_N-1:0];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // R15: Port module polarity applied before raw, detection and flag.
  assign portmod_raw_level = ~(portmod_irq ^ portmod_polarity_reg);
  // R09: Write-one clear masks for both flag levels.
  assign pm_clear  = (bus_req.wr && bus_req.addr == OFF_PM_FLAG) ?
                     bus_req.wdata[PM_N-1:0] : PM_RST;
  assign src_clear = (bus_req.wr && bus_req.addr == OFF_SRC_FLAG) ?
                     bus_req.wdata[SRC_N-1:0] : SRC_RST;

  // Per module detection, flag and pending logic.
  generate
    for (genvar m = 0; m < PM_N; m++) begin : g_pm
      // R16: Same detection as the top-level sources.
      assign pm_hit[m] = trig_hit(portmod_detect_mode_reg[2*m+1:2*m],
                                  portmod_raw_level[m], pm_prev_reg[m]);
      // R16: Skip bit and enable as at the top level.
      assign portmod_pending_enabled[m] = portmod_enable_mask_reg[m] &
        (portmod_latch_skip_reg[m] ? portmod_raw_level[m]
                                   : portmod_latched_flag_reg[m]);
    end
  endgenerate

  // R16: A set in the same cycle as a clear wins, so no event is lost.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      portmod_latched_flag_reg <= PM_RST;
      pm_prev_reg              <= PM_RST;
    end else begin
      portmod_latched_flag_reg <= (portmod_latched_flag_reg & ~pm_clear) | pm_hit;
      pm_prev_reg              <= portmod_raw_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // R22: Aggregate at bit 0, pins at bits 1 and 2, blocks above.
  // R17: Pending port module bits are ORed into one source.
  // R04: Raw value is unlatched.
  assign source_raw_level = {block_irq, pin_level, |portmod_pending_enabled};
  // Per source detection and pending logic.
  generate
    for (genvar n = 0; n < SRC_N; n++) begin : g_src
      // R05: Level mode hits on every active cycle.
      // R06: Any-edge, falling and rising modes compare with the last value.
      assign src_hit[n] = trig_hit(source_detect_mode_reg[2*n+1:2*n],
                                   source_raw_level[n], src_prev_reg[n]);
      // R10: Only flagged and enabled sources go forward.
      // R11: The skip bit takes the raw value in place of the flag.
      assign source_pending_enabled[n] = source_enable_mask_reg[n] &
        (source_latch_skip_reg[n] ? source_raw_level[n]
                                  : source_latched_flag_reg[n]);
      // R05: Level mode sets the flag.
      chk_level_sets_flag: assert property (  // R05
        (source_detect_mode_reg[2*n+1:2*n] == DET_LEVEL && source_raw_level[n])
        |=> source_latched_flag_reg[n])
        else $error("level source did not set its flag");
      // R06: Any change sets the flag.
      chk_anyedge_sets_flag: assert property (  // R06
        (source_detect_mode_reg[2*n+1:2*n] == DET_ANY &&
         source_raw_level[n] != src_prev_reg[n])
        |=> source_latched_flag_reg[n])
        else $error("changed source did not set its flag");
      // R07: Without a falling edge a clear flag stays clear.
      chk_fall_only: assert property (  // R07
        (source_detect_mode_reg[2*n+1:2*n] == DET_FALL &&
         !source_latched_flag_reg[n] &&
         !(src_prev_reg[n] && !source_raw_level[n]))
        |=> !source_latched_flag_reg[n])
        else $error("falling mode flag set without a falling edge");
      // R08: A rise sets the flag.
      chk_rise_sets_flag: assert property (  // R08
        (source_detect_mode_reg[2*n+1:2*n] == DET_RISE &&
         source_raw_level[n] && !src_prev_reg[n])
        |=> source_latched_flag_reg[n])
        else $error("rising source did not set its flag");
      // R09: A clear with no event empties the flag.
      chk_clear_w1c: assert property (  // R09
        (src_clear[n] && !src_hit[n]) |=> !source_latched_flag_reg[n])
        else $error("write one did not clear the flag");
    end
  endgenerate

  // R09: Set wins over a write-one clear in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      source_latched_flag_reg <= SRC_RST;
      src_prev_reg            <= SRC_RST;
    end else begin
      source_latched_flag_reg <= (source_latched_flag_reg & ~src_clear) | src_hit;
      src_prev_reg            <= source_raw_level;
    end
  end

  // R17: Any enabled latched flag of a module without skip raises the aggregate source.
  chk_aggregate_or: assert property (  // R17
    (|(portmod_latched_flag_reg & portmod_enable_mask_reg & ~portmod_latch_skip_reg))
    |-> source_raw_level[SRC_AGG])
    else $error("aggregate source missed a pending module");

  ////////////////////////////////////////////////////////////////////////////
  // Destination masks and views.
  generate
    for (genvar d = 0; d < DST_N; d++) begin : g_dst
      // R13: Each destination ANDs pending sources with its own mask.
      // R14: The view is readable per destination.
      assign target_pending_view[d] = source_pending_enabled & target_source_mask_reg[d];
      assign dst_active[d]          = |target_pending_view[d];
    end
  endgenerate
  // Destination state is held in flops so each processor interrupt comes from one.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dst_reg <= '0;
    end else begin
      dst_reg <= dst_active;
    end
  end
  // R01: Processor interrupts at replication indices 0 and 1.
  assign processor_irq_a = dst_reg[DST_CPU_A];
  assign processor_irq_b = dst_reg[DST_CPU_B];

  // R02: Pin outputs at replication indices 2 and 3.
  // R03: Polarity fixed at exit; 1 means active high.
  // R19: Drive mode 0 keeps the driver on at both levels.
  // R20: Mode 1 with polarity 0 pulls low while asserted.
  // R23: In mode 1 the driver is off whenever the level would be high.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_output_a    <= 1'b1;
      irq_output_a_oe <= 1'b0;
      irq_output_b    <= 1'b1;
      irq_output_b_oe <= 1'b0;
    end else begin
      irq_output_a    <= ~(dst_active[DST_PIN_A] ^ pin_output_polarity_reg[0]);
      irq_output_a_oe <= ~pin_output_drive_mode_reg[0] |
                         (dst_active[DST_PIN_A] ^ pin_output_polarity_reg[0]);
      irq_output_b    <= ~(dst_active[DST_PIN_B] ^ pin_output_polarity_reg[1]);
      irq_output_b_oe <= ~pin_output_drive_mode_reg[1] |
                         (dst_active[DST_PIN_B] ^ pin_output_polarity_reg[1]);
    end
  end

  // R13: A mapped pending source raises the processor interrupt next cycle.
  chk_dest_follows_map: assert property (  // R13
    (|(source_pending_enabled & target_source_mask_reg[DST_CPU_A]))
    |=> processor_irq_a)
    else $error("mapped pending source did not raise destination");
  // R19: Drive mode 0 keeps the pin driven.
  chk_pin_push_pull: assert property (  // R19
    !pin_output_drive_mode_reg[0] |=> irq_output_a_oe)
    else $error("push-pull pin was released");
  // R23: Open collector releases the pin while not asserted.
  sequence idle_open_collector;
    pin_output_drive_mode_reg[1] && !pin_output_polarity_reg[1] &&
    !dst_active[DST_PIN_B];
  endsequence
  sequence pulled_low_open_collector;
    pin_output_drive_mode_reg[1] && !pin_output_polarity_reg[1] &&
    dst_active[DST_PIN_B];
  endsequence
  chk_open_collector_idle: assert property (  // R23
    idle_open_collector |=> !irq_output_b_oe)
    else $error("open collector pin driven while idle");
  chk_open_collector_low: assert property (  // R20
    pulled_low_open_collector |=> irq_output_b_oe && !irq_output_b)
    else $error("open collector pin not pulled low");

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets read zero and unused upper bits read zero.
  always_comb begin
    rdata_next = '0;
    case (bus_req.addr)
      OFF_SRC_RAW:     rdata_next = 32'(source_raw_level);
      OFF_SRC_SKIP:    rdata_next = 32'(source_latch_skip_reg);
      OFF_SRC_MODE_LO: rdata_next = source_detect_mode_reg[MODE_LO_W-1:0];
      OFF_SRC_MODE_HI: rdata_next = 32'(source_detect_mode_reg[2*SRC_N-1:MODE_LO_W]);
      OFF_SRC_FLAG:    rdata_next = 32'(source_latched_flag_reg);
      OFF_SRC_ENA:     rdata_next = 32'(source_enable_mask_reg);
      OFF_SRC_PEND:    rdata_next = 32'(source_pending_enabled);
      OFF_PM_POL:      rdata_next = 32'(portmod_polarity_reg);
      OFF_PM_RAW:      rdata_next = 32'(portmod_raw_level);
      OFF_PM_SKIP:     rdata_next = 32'(portmod_latch_skip_reg);
      OFF_PM_MODE:     rdata_next = 32'(portmod_detect_mode_reg);
      OFF_PM_FLAG:     rdata_next = 32'(portmod_latched_flag_reg);
      OFF_PM_ENA:      rdata_next = 32'(portmod_enable_mask_reg);
      OFF_PM_PEND:     rdata_next = 32'(portmod_pending_enabled);
      OFF_PIN_IN_POL:  rdata_next = 32'(pin_input_polarity_reg);
      OFF_PIN_OUT_POL: rdata_next = 32'(pin_output_polarity_reg);
      OFF_PIN_DRV:     rdata_next = 32'(pin_output_drive_mode_reg);
      default: begin
        for (int d = 0; d < DST_N; d++) begin
          if (bus_req.addr == 8'(OFF_DST_MAP + DST_STRIDE * d))
            rdata_next = 32'(target_source_mask_reg[d]);
          if (bus_req.addr == 8'(OFF_DST_VIEW + DST_STRIDE * d))
            rdata_next = 32'(target_pending_view[d]);
        end
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bus_rdata <= '0;
    end else begin
      bus_rdata <= bus_req.rd ? rdata_next : '0;
    end
  end

  // R14: A read of a destination view returns its value from the strobe cycle.
  chk_view_readback: assert property (  // R14
    (bus_req.rd && bus_req.addr == OFF_DST_VIEW)
    |=> bus_rdata == 32'($past(target_pending_view[DST_CPU_A])))
    else $error("destination view read back wrong");
  // R10: Without skip or enable, block source 0 never shows pending.
  chk_pending_and: assert property (  // R10
    (!source_latch_skip_reg[SRC_BLK] && !source_enable_mask_reg[SRC_BLK])
    |-> !source_pending_enabled[SRC_BLK])
    else $error("disabled source shows pending");

endmodule

// ### core/intr_pkg.sv
package intr_pkg;

  // Source, port module, destination and pin counts.
  localparam int SRC_N     = 24;
  localparam int PM_N      = 11;
  localparam int DST_N     = 4;
  localparam int EXT_N     = 2;
  localparam int MODE_LO_W = 32;

  // Source bit positions.
  localparam int SRC_AGG   = 0;
  localparam int SRC_PIN_A = 1;
  localparam int SRC_PIN_B = 2;
  localparam int SRC_BLK   = 3;

  // Destination replication indices.
  localparam int DST_CPU_A = 0;
  localparam int DST_CPU_B = 1;
  localparam int DST_PIN_A = 2;
  localparam int DST_PIN_B = 3;

  // Register offsets.
  localparam logic [7:0] OFF_SRC_RAW     = 8'h00;
  localparam logic [7:0] OFF_SRC_SKIP    = 8'h04;
  localparam logic [7:0] OFF_SRC_MODE_LO = 8'h08;
  localparam logic [7:0] OFF_SRC_MODE_HI = 8'h0c;
  localparam logic [7:0] OFF_SRC_FLAG    = 8'h10;
  localparam logic [7:0] OFF_SRC_ENA     = 8'h14;
  localparam logic [7:0] OFF_SRC_PEND    = 8'h18;
  localparam logic [7:0] OFF_DST_MAP     = 8'h20;
  localparam logic [7:0] OFF_DST_VIEW    = 8'h30;
  localparam logic [7:0] DST_STRIDE      = 8'h04;
  localparam logic [7:0] OFF_PM_POL      = 8'h40;
  localparam logic [7:0] OFF_PM_RAW      = 8'h44;
  localparam logic [7:0] OFF_PM_SKIP     = 8'h48;
  localparam logic [7:0] OFF_PM_MODE     = 8'h4c;
  localparam logic [7:0] OFF_PM_FLAG     = 8'h50;
  localparam logic [7:0] OFF_PM_ENA      = 8'h54;
  localparam logic [7:0] OFF_PM_PEND     = 8'h58;
  localparam logic [7:0] OFF_PIN_IN_POL  = 8'h60;
  localparam logic [7:0] OFF_PIN_OUT_POL = 8'h64;
  localparam logic [7:0] OFF_PIN_DRV     = 8'h68;

  // Reset values.
  localparam logic [SRC_N-1:0]   SRC_RST      = 24'h000000;
  localparam logic [2*SRC_N-1:0] SRC_MODE_RST = 48'h000000000000;
  localparam logic [PM_N-1:0]    PM_RST       = 11'h000;
  localparam logic [PM_N-1:0]    PM_POL_RST   = 11'h7ff;
  localparam logic [2*PM_N-1:0]  PM_MODE_RST  = 22'h000000;
  localparam logic [EXT_N-1:0]   PIN_RST      = 2'h0;
  // Pins idle high while their input polarity resets to active low.
  localparam logic [EXT_N-1:0]   PIN_IDLE_RST = 2'h3;

  // Detection modes.
  typedef enum logic [1:0] {
    DET_LEVEL = 2'b00,
    DET_ANY   = 2'b01,
    DET_FALL  = 2'b10,
    DET_RISE  = 2'b11
  } detect_e;

  // One register port request.
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_s;

  // Event detection for one active-high source bit.
  function automatic logic trig_hit(input logic [1:0] mode, input logic cur,
                                    input logic prev);
    case (detect_e'(mode))
      DET_LEVEL: trig_hit = cur;
      DET_ANY:   trig_hit = cur ^ prev;
      // R07: Active to inactive.
      DET_FALL:  trig_hit = prev & ~cur;
      // R08: Inactive to active.
      DET_RISE:  trig_hit = cur & ~prev;
      default:   trig_hit = 1'b0;
    endcase
  endfunction

endpackage

// ### test/irq_far_side.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Board wire behind one pin target, with a pull-up resistor on it.
module irq_far_side (
  // Design driver side.
  input  wire logic level,
  input  wire logic oe,
  // Resolved wire seen by the board.
  output logic      wire_level
);
  // open collector
  // A released wire floats up to the pull-up, never to the last driven value.
  assign wire_level = oe ? level : 1'b1;
endmodule

// ### test/sticky_interrupt_router_tb_top.sv
`timescale 1ns/10ps
module sticky_interrupt_router_tb_top;
  import intr_pkg::*;
  reg_req_s    bus_req = '0;
  logic        clk_sys = 1'b0, reset = 1'b1, irq_input_a = 1'b1, irq_input_b = 1'b1;
  logic [31:0] bus_rdata, seed = 32'ha48b;
  logic [20:0] block_irq = '0;
  logic [10:0] portmod_irq = '0;
  logic        processor_irq_a, processor_irq_b, irq_output_a, irq_output_a_oe;
  logic        irq_output_b, irq_output_b_oe, wire_a, wire_b;
  int          fail_count = 0, tests_run = 0, cyc = 0;
  // Model flags of the mode scenario, queued in the order they are read.
  int          exp_q [$];
  int          mflag;
  ////////////////////////////////////////////////////////////////////////////
  sticky_interrupt_router DUT (.clk_sys(clk_sys), .reset(reset), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .block_irq(block_irq), .portmod_irq(portmod_irq),
    .irq_input_a(irq_input_a), .irq_input_b(irq_input_b),
    .processor_irq_a(processor_irq_a), .processor_irq_b(processor_irq_b),
    .irq_output_a(irq_output_a), .irq_output_a_oe(irq_output_a_oe),
    .irq_output_b(irq_output_b), .irq_output_b_oe(irq_output_b_oe));
  irq_far_side far_a (.level(irq_output_a), .oe(irq_output_a_oe), .wire_level(wire_a));
  irq_far_side far_b (.level(irq_output_b), .oe(irq_output_b_oe), .wire_level(wire_b));
  // Free-running 125 MHz clock.
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  // Cuts a hang short; the run needs well under a thousand cycles.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // Rule model of one detection step: level, any edge, falling, rising.
  function automatic int m_hit(input int mode, input int cur, input int prev);
    case (mode)
      0:       return cur;
      1:       return int'(cur != prev);
      2:       return int'(prev == 1 && cur == 0);
      default: return int'(cur == 1 && prev == 0);
    endcase
  endfunction
  task automatic ticks(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t reg got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_out(input logic [5:0] exp);
    logic [5:0] got;
    got = {processor_irq_a, processor_irq_b, irq_output_a_oe, wire_a, irq_output_b_oe, wire_b};
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t out got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= 1'b1;
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1 cmp_reg(bus_rdata, exp);
  endtask
  task automatic src(input logic v);
    @(posedge clk_sys);
    block_irq[0] <= v;
  endtask
  task automatic give_verdict();
    if (fail_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; block source 0 is source bit 3 throughout.
  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    ticks(3);
    rd(OFF_SRC_ENA, 32'h0);
    rd(OFF_PM_POL, 32'h7ff);
    rd(8'h7c, 32'h0);
    cmp_out(6'h0f);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      @(posedge clk_sys) block_irq <= seed[20:0];
      ticks(2);
      rd(OFF_SRC_RAW, {8'h00, seed[20:0], 3'h0});
    end
    @(posedge clk_sys) block_irq <= '0;
    for (int m = 0; m < 4; m++) begin
      // Model: flag after the rise, after a clear while high, after the fall.
      mflag = m_hit(m, 1, 0) | m_hit(m, 1, 1);
      exp_q.push_back(mflag);
      mflag = m_hit(m, 1, 1);
      exp_q.push_back(mflag);
      mflag = mflag | m_hit(m, 0, 1) | m_hit(m, 0, 0);
      exp_q.push_back(mflag);
      wr(OFF_SRC_MODE_LO, 32'(m) << 6);
      wr(OFF_SRC_FLAG, 32'hffffff);
      src(1'b1);
      ticks(3);
      rd(OFF_SRC_FLAG, 32'(exp_q.pop_front()) << 3);
      wr(OFF_SRC_FLAG, 32'h8);
      ticks(1);
      rd(OFF_SRC_FLAG, 32'(exp_q.pop_front()) << 3);
      src(1'b0);
      ticks(3);
      rd(OFF_SRC_FLAG, 32'(exp_q.pop_front()) << 3);
    end
    wr(OFF_SRC_MODE_LO, 32'h0);
    wr(OFF_SRC_FLAG, 32'h8);
    // drive mode set before the pin goes live
    wr(OFF_PIN_DRV, 32'h3);
    wr(OFF_SRC_ENA, 32'h8);
    wr(OFF_DST_MAP, 32'h8);
    wr(OFF_DST_MAP + 8'h08, 32'h8);
    wr(OFF_DST_MAP + 8'h0c, 32'h8);
    src(1'b1);
    ticks(4);
    cmp_out(6'h2a);
    rd(OFF_SRC_PEND, 32'h8);
    rd(OFF_DST_VIEW, 32'h8);
    rd(OFF_DST_VIEW + 8'h04, 32'h0);
    rd(OFF_DST_VIEW + 8'h08, 32'h8);
    rd(OFF_DST_VIEW + 8'h0c, 32'h8);
    src(1'b0);
    wr(OFF_SRC_FLAG, 32'h8);
    ticks(3);
    cmp_out(6'h05);
    wr(OFF_SRC_ENA, 32'h0);
    src(1'b1);
    ticks(3);
    rd(OFF_SRC_PEND, 32'h0);
    src(1'b0);
    wr(OFF_SRC_ENA, 32'h8);
    // skip only while the source sits still, as a sticky origin would
    wr(OFF_SRC_SKIP, 32'h8);
    ticks(2);
    rd(OFF_SRC_PEND, 32'h0);
    wr(OFF_SRC_SKIP, 32'h0);
    rd(OFF_SRC_PEND, 32'h8);
    wr(OFF_SRC_ENA, 32'h0);
    wr(OFF_PM_ENA, 32'h1);
    wr(OFF_SRC_ENA, 32'h1);
    wr(OFF_DST_MAP + 8'h04, 32'h1);
    @(posedge clk_sys) portmod_irq[0] <= 1'b1;
    ticks(5);
    cmp_out(6'h15);
    rd(OFF_PM_PEND, 32'h1);
    wr(OFF_PM_POL, 32'h7fe);
    @(posedge clk_sys) portmod_irq[0] <= 1'b0;
    ticks(2);
    rd(OFF_PM_RAW, 32'h1);
    @(posedge clk_sys) irq_input_b <= 1'b0;
    ticks(4);
    rd(OFF_SRC_RAW, 32'h5);
    wr(OFF_PIN_IN_POL, 32'h1);
    rd(OFF_SRC_RAW, 32'h7);
    give_verdict();
  end
endmodule
